/* src/pim_mapper.sv */
// Purpose: builds the cyclic input image and splits the output image
// Assumes: fetch source answers in the same cycle as o_fetch_req
// Notes: empty positions cost one idle cycle each while walking
`timescale 1ns/1ps
`default_nettype none
`include "pim_regs.svh"

//Operation
// - Module bytes fill both images in position order from position 0.
// - With diagnostics on, diagnostic bytes open the input image.
// - Each image is at least two bytes, padded up from zero or one.
// - An odd image byte count gets exactly one pad byte to become even.
// - Interface unit: 4 out bytes, 4 in bytes only with diagnostics on.
// - Digital modules take a byte per 8 points, mixed ones one each way.
// - Analogue, temperature and counter units take 2 bytes per channel.
// - Sensor master takes 44, 70 or 134 bytes each way per its switch.
module pim_mapper
   import pim_pkg::*;
#(
   parameter int N_SLOTS = 10
)
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [N_SLOTS*4-1:0] i_slot_kind,
   input wire logic [N_SLOTS*2-1:0] i_sm_size,
   input wire logic i_diag_en,
   input wire logic i_in_start,
   output logic o_fetch_req,
   output logic o_fetch_diag,
   output logic [7:0] o_fetch_slot,
   output logic [7:0] o_fetch_idx,
   input wire logic [7:0] i_fetch_byte,
   output logic o_in_valid,
   output logic [7:0] o_in_byte,
   output logic o_in_done,
   output logic o_in_busy,
   input wire logic i_out_start,
   input wire logic i_out_valid,
   input wire logic [7:0] i_out_byte,
   output logic o_out_ready,
   output logic o_wr_valid,
   output logic [7:0] o_wr_slot,
   output logic [7:0] o_wr_idx,
   output logic [7:0] o_wr_byte,
   output logic o_out_done
);

   localparam int SW = $clog2(N_SLOTS + 1);
   localparam logic [SW-1:0] LAST_SLOT = SW'(N_SLOTS);

   // input image walker
   pim_iw_st_t iw_st_ff, nxt_iw_st;
   logic [SW-1:0] iw_slot_ff, nxt_iw_slot;
   logic [7:0] iw_idx_ff, nxt_iw_idx;
   logic [15:0] iw_cnt_ff, nxt_iw_cnt;
   logic pend_pad_ff, nxt_pend_pad;
   logic pend_done_ff, nxt_pend_done;
   logic nxt_fetch_req, nxt_fetch_diag;

   wire iw_at_end = (iw_slot_ff == LAST_SLOT);
   wire [SW-1:0] iw_sel = iw_at_end ? '0 : iw_slot_ff;
   wire [3:0] iw_kind = i_slot_kind[iw_sel*4 +: 4];
   wire [1:0] iw_sm = i_sm_size[iw_sel*2 +: 2];
   wire [7:0] iw_in_sz;
   wire [7:0] iw_unused_out;
   // interface unit input bytes already went out as diagnostics
   wire [7:0] iw_eff_sz = (iw_kind == PIM_K_SI) ? 8'h00 : iw_in_sz;
   wire iw_pad_need = (iw_cnt_ff < `PIM_MIN_IMAGE) ||
                      iw_cnt_ff[0];

   pim_size_lut u_iw_lut (
      .i_kind(iw_kind),
      .i_sm_size(iw_sm),
      .i_diag_en(i_diag_en),
      .o_in_bytes(iw_in_sz),
      .o_out_bytes(iw_unused_out)
   );

   always_comb begin
      nxt_iw_st = iw_st_ff;
      nxt_iw_slot = iw_slot_ff;
      nxt_iw_idx = iw_idx_ff;
      nxt_iw_cnt = iw_cnt_ff;
      nxt_fetch_req = 1'b0;
      nxt_fetch_diag = 1'b0;
      nxt_pend_pad = 1'b0;
      nxt_pend_done = 1'b0;
      case (iw_st_ff)
         PIM_IW_IDLE: begin
            if (i_in_start) begin
               nxt_iw_slot = '0;
               nxt_iw_idx = 8'h00;
               nxt_iw_cnt = 16'h0000;
               nxt_iw_st = i_diag_en ? PIM_IW_DIAG : PIM_IW_MOD;
            end
         end
         PIM_IW_DIAG: begin
            nxt_fetch_req = 1'b1;
            nxt_fetch_diag = 1'b1;
            nxt_iw_cnt = iw_cnt_ff + 16'h0001;
            if (iw_idx_ff == `PIM_DIAG_BYTES - 8'h01) begin
               nxt_iw_idx = 8'h00;
               nxt_iw_st = PIM_IW_MOD;
            end else begin
               nxt_iw_idx = iw_idx_ff + 8'h01;
            end
         end
         PIM_IW_MOD: begin
            if (iw_at_end) begin
               nxt_iw_st = PIM_IW_PAD;
            end else if (iw_eff_sz == 8'h00) begin
               nxt_iw_slot = iw_slot_ff + SW'(1);
            end else begin
               nxt_fetch_req = 1'b1;
               nxt_iw_cnt = iw_cnt_ff + 16'h0001;
               if (iw_idx_ff == iw_eff_sz - 8'h01) begin
                  nxt_iw_idx = 8'h00;
                  nxt_iw_slot = iw_slot_ff + SW'(1);
               end else begin
                  nxt_iw_idx = iw_idx_ff + 8'h01;
               end
            end
         end
         PIM_IW_PAD: begin
            if (iw_pad_need) begin
               nxt_pend_pad = 1'b1;
               nxt_iw_cnt = iw_cnt_ff + 16'h0001;
            end else begin
               nxt_pend_done = 1'b1;
               nxt_iw_st = PIM_IW_IDLE;
            end
         end
         default: nxt_iw_st = PIM_IW_IDLE;
      endcase
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         iw_st_ff <= PIM_IW_IDLE;
         iw_slot_ff <= '0;
         iw_idx_ff <= 8'h00;
         iw_cnt_ff <= 16'h0000;
         o_fetch_req <= 1'b0;
         o_fetch_diag <= 1'b0;
         o_fetch_slot <= 8'h00;
         o_fetch_idx <= 8'h00;
         pend_pad_ff <= 1'b0;
         pend_done_ff <= 1'b0;
      end else begin
         iw_st_ff <= nxt_iw_st;
         iw_slot_ff <= nxt_iw_slot;
         iw_idx_ff <= nxt_iw_idx;
         iw_cnt_ff <= nxt_iw_cnt;
         o_fetch_req <= nxt_fetch_req;
         o_fetch_diag <= nxt_fetch_diag;
         o_fetch_slot <= nxt_fetch_diag ? 8'h00 : 8'(iw_slot_ff);
         o_fetch_idx <= iw_idx_ff;
         pend_pad_ff <= nxt_pend_pad;
         pend_done_ff <= nxt_pend_done;
      end
   end

   // second stage: fetched byte or a zero pad byte leaves the block
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_in_valid <= 1'b0;
         o_in_byte <= 8'h00;
         o_in_done <= 1'b0;
         o_in_busy <= 1'b0;
      end else begin
         o_in_valid <= o_fetch_req || pend_pad_ff;
         o_in_byte <= o_fetch_req ? i_fetch_byte : 8'h00;
         o_in_done <= pend_done_ff;
         o_in_busy <= (iw_st_ff != PIM_IW_IDLE) || o_fetch_req || pend_pad_ff;
      end
   end

   // output image walker
   pim_ow_st_t ow_st_ff, nxt_ow_st;
   logic [SW-1:0] ow_slot_ff, nxt_ow_slot;
   logic [7:0] ow_idx_ff, nxt_ow_idx;
   logic [15:0] ow_cnt_ff, nxt_ow_cnt;
   logic nxt_out_ready, nxt_wr_valid, nxt_out_done;

   wire ow_at_end = (ow_slot_ff == LAST_SLOT);
   wire [SW-1:0] ow_sel = ow_at_end ? '0 : ow_slot_ff;
   wire [3:0] ow_kind = i_slot_kind[ow_sel*4 +: 4];
   wire [1:0] ow_sm = i_sm_size[ow_sel*2 +: 2];
   wire [7:0] ow_out_sz;
   wire [7:0] ow_unused_in;
   wire ow_take = i_out_valid && o_out_ready;
   wire [15:0] ow_cnt_inc = ow_cnt_ff + 16'h0001;
   wire ow_pad_now = (ow_cnt_ff < `PIM_MIN_IMAGE) ||
                     ow_cnt_ff[0];
   wire ow_pad_inc = (ow_cnt_inc < `PIM_MIN_IMAGE) ||
                     ow_cnt_inc[0];

   pim_size_lut u_ow_lut (
      .i_kind(ow_kind),
      .i_sm_size(ow_sm),
      .i_diag_en(i_diag_en),
      .o_in_bytes(ow_unused_in),
      .o_out_bytes(ow_out_sz)
   );

   always_comb begin
      nxt_ow_st = ow_st_ff;
      nxt_ow_slot = ow_slot_ff;
      nxt_ow_idx = ow_idx_ff;
      nxt_ow_cnt = ow_cnt_ff;
      nxt_out_ready = o_out_ready;
      nxt_wr_valid = 1'b0;
      nxt_out_done = 1'b0;
      case (ow_st_ff)
         PIM_OW_IDLE: begin
            nxt_out_ready = 1'b0;
            if (i_out_start) begin
               nxt_ow_slot = '0;
               nxt_ow_idx = 8'h00;
               nxt_ow_cnt = 16'h0000;
               nxt_ow_st = PIM_OW_SEEK;
            end
         end
         PIM_OW_SEEK: begin
            if (ow_at_end) begin
               nxt_ow_st = PIM_OW_PAD;
               nxt_out_ready = ow_pad_now;
            end else if (ow_out_sz == 8'h00) begin
               nxt_ow_slot = ow_slot_ff + SW'(1);
            end else begin
               nxt_ow_st = PIM_OW_TAKE;
               nxt_out_ready = 1'b1;
            end
         end
         PIM_OW_TAKE: begin
            if (ow_take) begin
               nxt_wr_valid = 1'b1;
               nxt_ow_cnt = ow_cnt_inc;
               if (ow_idx_ff == ow_out_sz - 8'h01) begin
                  nxt_ow_idx = 8'h00;
                  nxt_ow_slot = ow_slot_ff + SW'(1);
                  nxt_ow_st = PIM_OW_SEEK;
                  nxt_out_ready = 1'b0;
               end else begin
                  nxt_ow_idx = ow_idx_ff + 8'h01;
               end
            end
         end
         PIM_OW_PAD: begin
            // padding bytes are swallowed, never written anywhere
            if (!o_out_ready) begin
               nxt_out_done = 1'b1;
               nxt_ow_st = PIM_OW_IDLE;
            end else if (ow_take) begin
               nxt_ow_cnt = ow_cnt_inc;
               nxt_out_ready = ow_pad_inc;
            end
         end
         default: nxt_ow_st = PIM_OW_IDLE;
      endcase
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ow_st_ff <= PIM_OW_IDLE;
         ow_slot_ff <= '0;
         ow_idx_ff <= 8'h00;
         ow_cnt_ff <= 16'h0000;
         o_out_ready <= 1'b0;
         o_wr_valid <= 1'b0;
         o_wr_slot <= 8'h00;
         o_wr_idx <= 8'h00;
         o_wr_byte <= 8'h00;
         o_out_done <= 1'b0;
      end else begin
         ow_st_ff <= nxt_ow_st;
         ow_slot_ff <= nxt_ow_slot;
         ow_idx_ff <= nxt_ow_idx;
         ow_cnt_ff <= nxt_ow_cnt;
         o_out_ready <= nxt_out_ready;
         o_wr_valid <= nxt_wr_valid;
         o_wr_slot <= 8'(ow_slot_ff);
         o_wr_idx <= ow_idx_ff;
         o_wr_byte <= i_out_byte;
         o_out_done <= nxt_out_done;
      end
   end

endmodule : pim_mapper
`default_nettype wire

/* src/pim_regs.svh */
// Purpose: byte allocations and image limits of the process image mapper
// Assumes: byte counts fit in 8 bits, image lengths in 16 bits
// Notes: definitions only
`ifndef PIM_REGS_SVH
`define PIM_REGS_SVH

`define PIM_SI_OUT_BYTES 8'h04
`define PIM_DIAG_BYTES 8'h04
`define PIM_DIG8_BYTES 8'h01
`define PIM_DIG16_BYTES 8'h02
`define PIM_CH_BYTES 8'h02
`define PIM_SM_BYTES_S 8'h2C
`define PIM_SM_BYTES_M 8'h46
`define PIM_SM_BYTES_L 8'h86
`define PIM_MIN_IMAGE 16'h0002

`endif

/* src/pim_pkg.sv */
// Purpose: types shared by the process image mapper files
// Assumes: nothing beyond the header of allocations
// Notes: kind codes are the configuration inputs per module position
package pim_pkg;

   typedef enum logic [3:0] {
      PIM_K_EMPTY = 4'h0,
      PIM_K_SI = 4'h1,
      PIM_K_DI8 = 4'h2,
      PIM_K_DI16 = 4'h3,
      PIM_K_DO8 = 4'h4,
      PIM_K_DO16 = 4'h5,
      PIM_K_DM8 = 4'h6,
      PIM_K_AI2 = 4'h7,
      PIM_K_AI4 = 4'h8,
      PIM_K_AO2 = 4'h9,
      PIM_K_AM2 = 4'hA,
      PIM_K_TEMP4 = 4'hB,
      PIM_K_FRQ4 = 4'hC,
      PIM_K_SMASTER = 4'hD
   } pim_kind_t;

   typedef enum logic [1:0] {
      PIM_SM_S = 2'h0,
      PIM_SM_M = 2'h1,
      PIM_SM_L = 2'h2,
      PIM_SM_L2 = 2'h3
   } pim_smsize_t;

   typedef enum logic [1:0] {
      PIM_IW_IDLE = 2'b00,
      PIM_IW_DIAG = 2'b01,
      PIM_IW_MOD = 2'b10,
      PIM_IW_PAD = 2'b11
   } pim_iw_st_t;

   typedef enum logic [1:0] {
      PIM_OW_IDLE = 2'b00,
      PIM_OW_SEEK = 2'b01,
      PIM_OW_TAKE = 2'b10,
      PIM_OW_PAD = 2'b11
   } pim_ow_st_t;

endpackage : pim_pkg

/* src/pim_size_lut.sv */
// Purpose: input and output byte allocation of one module position
// Assumes: kind and switch are stable while looked up
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "pim_regs.svh"

module pim_size_lut
   import pim_pkg::*;
(
   input wire logic [3:0] i_kind,
   input wire logic [1:0] i_sm_size,
   input wire logic i_diag_en,
   output logic [7:0] o_in_bytes,
   output logic [7:0] o_out_bytes
);

   wire [7:0] sm_bytes;

   assign sm_bytes = (i_sm_size == PIM_SM_S) ? `PIM_SM_BYTES_S :
                     (i_sm_size == PIM_SM_M) ? `PIM_SM_BYTES_M :
                     `PIM_SM_BYTES_L;

   always_comb begin
      o_in_bytes = 8'h00;
      o_out_bytes = 8'h00;
      case (pim_kind_t'(i_kind))
         PIM_K_SI: begin
            o_out_bytes = `PIM_SI_OUT_BYTES;
            o_in_bytes = i_diag_en ? `PIM_DIAG_BYTES : 8'h00;
         end
         PIM_K_DI8: o_in_bytes = `PIM_DIG8_BYTES;
         PIM_K_DI16: o_in_bytes = `PIM_DIG16_BYTES;
         PIM_K_DO8: o_out_bytes = `PIM_DIG8_BYTES;
         PIM_K_DO16: o_out_bytes = `PIM_DIG16_BYTES;
         PIM_K_DM8: begin
            o_in_bytes = `PIM_DIG8_BYTES;
            o_out_bytes = `PIM_DIG8_BYTES;
         end
         PIM_K_AI2: o_in_bytes = `PIM_CH_BYTES * 8'h02;
         PIM_K_AI4: o_in_bytes = `PIM_CH_BYTES * 8'h04;
         PIM_K_AO2: o_out_bytes = `PIM_CH_BYTES * 8'h02;
         PIM_K_AM2: begin
            o_in_bytes = `PIM_CH_BYTES * 8'h02;
            o_out_bytes = `PIM_CH_BYTES * 8'h02;
         end
         PIM_K_TEMP4: o_in_bytes = `PIM_CH_BYTES * 8'h04;
         PIM_K_FRQ4: o_in_bytes = `PIM_CH_BYTES * 8'h04;
         PIM_K_SMASTER: begin
            o_in_bytes = sm_bytes;
            o_out_bytes = sm_bytes;
         end
         default: begin
            o_in_bytes = 8'h00;
            o_out_bytes = 8'h00;
         end
      endcase
   end

endmodule : pim_size_lut
`default_nettype wire

/* verification/pim_mapper_properties.sv */
// Purpose: port-level checks of the process image mapper
// Assumes: one clock domain, async active-low reset
// Notes: bound onto every pim_mapper instance
`timescale 1ns/1ps
`default_nettype none

module pim_mapper_props (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_diag_en,
   input wire logic [7:0] i_fetch_byte,
   input wire logic o_fetch_req,
   input wire logic o_fetch_diag,
   input wire logic [7:0] o_fetch_slot,
   input wire logic [7:0] o_fetch_idx,
   input wire logic o_in_valid,
   input wire logic [7:0] o_in_byte,
   input wire logic o_in_done,
   input wire logic o_in_busy,
   input wire logic i_out_valid,
   input wire logic [7:0] i_out_byte,
   input wire logic o_out_ready,
   input wire logic o_wr_valid,
   input wire logic [7:0] o_wr_byte,
   input wire logic o_out_done
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_n);

   fetch_echo_a: assert property (o_fetch_req |=> o_in_valid &&
      o_in_byte == $past(i_fetch_byte)) else $error("fetched byte lost");
   idx_step_a: assert property (o_fetch_req && $past(o_fetch_req) &&
      o_fetch_slot == $past(o_fetch_slot) &&
      o_fetch_diag == $past(o_fetch_diag)
      |-> o_fetch_idx == $past(o_fetch_idx) + 8'h01) else $error("index skip");
   slot_order_a: assert property (o_fetch_req && !o_fetch_diag &&
      $past(o_fetch_req) && !$past(o_fetch_diag)
      |-> o_fetch_slot >= $past(o_fetch_slot)) else $error("slot order");
   diag_gate_a: assert property (o_fetch_req && o_fetch_diag
      |-> i_diag_en && o_fetch_slot == 8'h00) else $error("diag fetch");
   pad_zero_a: assert property (o_in_valid && !$past(o_fetch_req)
      |-> o_in_byte == 8'h00) else $error("pad byte not zero");
   // empty tail positions delay done, so only the busy fall is fixed
   in_done_a: assert property (o_in_done
      |-> !o_in_valid && !o_in_busy && $past(o_in_busy))
      else $error("input done");
   wr_source_a: assert property (o_wr_valid
      |-> $past(i_out_valid) && $past(o_out_ready) &&
      o_wr_byte == $past(i_out_byte)) else $error("write not taken");
   out_done_a: assert property (o_out_done
      |-> !o_out_ready && !o_wr_valid) else $error("output done");

   cover property (o_fetch_req && o_fetch_diag);
   cover property (o_in_done);
   cover property (o_out_done);
   cover property (o_in_valid && !$past(o_fetch_req));
endmodule : pim_mapper_props

bind pim_mapper pim_mapper_props i_pim_mapper_props (.i_clk, .i_rst_n,
   .i_diag_en, .i_fetch_byte, .o_fetch_req, .o_fetch_diag, .o_fetch_slot,
   .o_fetch_idx, .o_in_valid, .o_in_byte, .o_in_done, .o_in_busy, .i_out_valid,
   .i_out_byte, .o_out_ready, .o_wr_valid, .o_wr_byte, .o_out_done);

`default_nettype wire

/* verification/pim_scanner_model.sv */
// Purpose: module data source and scanner output stream
// Assumes: fetch answered in the same cycle as the request
// Notes: random stalls on the stream; lines scrambled when idle
`timescale 1ns/1ps
`default_nettype none

module pim_scanner_model (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_req,
   input wire logic i_diag,
   input wire logic [7:0] i_slot,
   input wire logic [7:0] i_idx,
   output logic [7:0] o_byte,
   input wire logic i_go,
   input wire logic [15:0] i_len,
   input wire logic i_ready,
   output logic o_valid,
   output logic [7:0] o_data
);
   logic [7:0] cnt_ff;
   logic [7:0] tick_ff;
   logic [15:0] left_ff;
   // unrequested data must never look like a stale answer
   assign o_byte = i_req ? (i_slot * 8'h1D + i_idx) ^ (i_diag ? 8'hA5 : 8'h00)
                         : tick_ff;
   assign o_data = o_valid ? 8'h30 + cnt_ff : ~tick_ff;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_ff <= 8'h00;
         tick_ff <= 8'h00;
         left_ff <= 16'h0000;
         o_valid <= 1'b0;
      end else begin
         tick_ff <= tick_ff + 8'h3B;
         if (o_valid && i_ready) begin
            o_valid <= 1'b0;
            cnt_ff <= cnt_ff + 8'h01;
            left_ff <= left_ff - 16'h0001;
         end else if (i_go) begin
            left_ff <= i_len;
            cnt_ff <= 8'h00;
         end else if (!o_valid && left_ff != 16'h0000 &&
                      $urandom % 4 != 0) begin
            o_valid <= 1'b1;
         end
      end
   end
endmodule : pim_scanner_model

`default_nettype wire

/* verification/pim_mapper_tb_top.sv */
// Purpose: self-checking bench of the process image mapper
// Assumes: scanner model answers fetches at once
// Notes: fixed corner cases, then random slot layouts
`timescale 1ns/1ps
`default_nettype none

module pim_mapper_tb_top;
   import pim_pkg::*;
   localparam int N = 4;
   localparam int NS = N * 2;
   logic i_clk = 0, i_rst_n = 0, i_diag_en = 0, i_in_start = 0;
   logic i_out_start = 0, go = 0;
   logic [N*4-1:0] i_slot_kind = '0;
   logic [N*2-1:0] i_sm_size = '0;
   logic [15:0] len = '0;
   wire logic o_fetch_req, o_fetch_diag, o_in_valid, o_in_done, o_in_busy;
   wire logic i_out_valid, o_out_ready, o_wr_valid, o_out_done;
   wire logic [7:0] o_fetch_slot, o_fetch_idx, i_fetch_byte, o_in_byte;
   wire logic [7:0] i_out_byte, o_wr_slot, o_wr_idx, o_wr_byte;
   int err_total = 0, tests_run = 0;
   logic [7:0] got_in[$], exp_in[$];
   logic [23:0] got_wr[$], exp_wr[$];

   always #5 i_clk = ~i_clk;

   pim_mapper #(.N_SLOTS(N)) i_pim_mapper (.i_clk, .i_rst_n, .i_slot_kind,
      .i_sm_size, .i_diag_en, .i_in_start, .o_fetch_req, .o_fetch_diag,
      .o_fetch_slot, .o_fetch_idx, .i_fetch_byte, .o_in_valid, .o_in_byte,
      .o_in_done, .o_in_busy, .i_out_start, .i_out_valid, .i_out_byte,
      .o_out_ready, .o_wr_valid, .o_wr_slot, .o_wr_idx, .o_wr_byte,
      .o_out_done);
   pim_scanner_model i_pim_scanner_model (.i_clk(i_clk), .i_rst_n(i_rst_n),
      .i_req(o_fetch_req), .i_diag(o_fetch_diag), .i_slot(o_fetch_slot),
      .i_idx(o_fetch_idx), .o_byte(i_fetch_byte), .i_go(go), .i_len(len),
      .i_ready(o_out_ready), .o_valid(i_out_valid), .o_data(i_out_byte));

   always @(posedge i_clk) begin
      if (o_in_valid) got_in.push_back(o_in_byte);
      if (o_wr_valid) got_wr.push_back({o_wr_slot, o_wr_idx, o_wr_byte});
   end

   function automatic int sm(logic [1:0] s);
      return s == 2'h0 ? 44 : (s == 2'h1 ? 70 : 134);
   endfunction : sm
   function automatic int insz(logic [3:0] k, logic [1:0] s);
      case (k)
         4'h2, 4'h6: return 1;
         4'h3: return 2;
         4'h7, 4'hA: return 4;
         4'h8, 4'hB, 4'hC: return 8;
         4'hD: return sm(s);
         default: return 0;
      endcase
   endfunction : insz
   function automatic int outsz(logic [3:0] k, logic [1:0] s);
      case (k)
         4'h4, 4'h6: return 1;
         4'h5: return 2;
         4'h1, 4'h9, 4'hA: return 4;
         4'hD: return sm(s);
         default: return 0;
      endcase
   endfunction : outsz
   function automatic int padded(int n);
      n = (n < 2) ? 2 : n;
      return n + n % 2;
   endfunction : padded

   task automatic tally_and_finish;
      $display("tests_run %0d err_total %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : tally_and_finish
   task automatic cmp_in(logic [7:0] g, logic [7:0] e);
      tests_run++;
      if (g !== e) begin
         err_total++;
         $display("BAD t=%0t in got %h exp %h", $time, g, e);
      end
   endtask : cmp_in
   task automatic cmp_wr(logic [23:0] g, logic [23:0] e);
      tests_run++;
      if (g !== e) begin
         err_total++;
         $display("BAD t=%0t wr got %h exp %h", $time, g, e);
      end
   endtask : cmp_wr
   task automatic cmp_cnt(logic [15:0] g, logic [15:0] e);
      tests_run++;
      if (g !== e) begin
         err_total++;
         $display("BAD t=%0t cnt got %h exp %h", $time, g, e);
      end
   endtask : cmp_cnt
   task automatic wait_done(bit outdir);
      int t = 0;
      while (!(outdir ? o_out_done : o_in_done) && t < 3000) begin
         @(negedge i_clk);
         t++;
      end
      if (t >= 3000) begin
         err_total++;
         tally_and_finish;
      end
   endtask : wait_done

   task automatic run(logic [N*4-1:0] k, logic [N*2-1:0] s, logic d);
      int m = 0;
      logic [3:0] kk;
      logic [1:0] ss;
      exp_in = {};
      exp_wr = {};
      got_in = {};
      got_wr = {};
      @(posedge i_clk);
      i_slot_kind <= k;
      i_sm_size <= s;
      i_diag_en <= d;
      if (d) for (int i = 0; i < 4; i++) exp_in.push_back(8'(i) ^ 8'hA5);
      for (int p = 0; p < N; p++) begin
         kk = k[4*p+:4];
         ss = s[2*p+:2];
         if (kk != 4'h1)
            for (int i = 0; i < insz(kk, ss); i++)
               exp_in.push_back(8'(p * 29 + i));
         for (int i = 0; i < outsz(kk, ss); i++) begin
            exp_wr.push_back({8'(p), 8'(i), 8'(8'h30 + m)});
            m++;
         end
      end
      while (exp_in.size() < padded(exp_in.size())) exp_in.push_back(8'h00);
      @(posedge i_clk);
      i_in_start <= 1'b1;
      @(posedge i_clk);
      i_in_start <= 1'b0;
      wait_done(0);
      cmp_cnt(16'(got_in.size()), 16'(exp_in.size()));
      cmp_cnt(16'(o_in_busy), 16'h0000);
      foreach (exp_in[i]) cmp_in(got_in[i], exp_in[i]);
      @(posedge i_clk);
      len <= 16'(padded(m));
      go <= 1'b1;
      i_out_start <= 1'b1;
      @(posedge i_clk);
      go <= 1'b0;
      i_out_start <= 1'b0;
      wait_done(1);
      cmp_cnt(i_pim_scanner_model.left_ff, 16'h0000);
      cmp_cnt(16'(got_wr.size()), 16'(exp_wr.size()));
      foreach (exp_wr[i]) cmp_wr(got_wr[i], exp_wr[i]);
      $display("test done, %0d in bytes, %0d out bytes", exp_in.size(), m);
   endtask : run

   initial begin
      logic [N*4-1:0] rk;
      void'($urandom(32'hE9F04C33));
      repeat (20) @(posedge i_clk);
      i_rst_n <= 1'b1;
      run('0, '0, 1'b0);
      run({8'h00, 4'h1, 4'h4}, '0, 1'b0);
      run({4{4'hD}}, 8'hE4, 1'b1);
      run({4'hC, 4'hB, 4'h9, 4'hA}, '0, 1'b1);
      run({4'h5, 4'h3, 4'h2, 4'h6}, '0, 1'b1);
      run({4'h8, 4'h7, 4'h4, 4'h2}, '0, 1'b0);
      repeat (14) begin
         for (int p = 0; p < N; p++) rk[4*p+:4] = 4'($urandom % 14);
         run(rk, NS'($urandom), 1'($urandom));
      end
      tally_and_finish;
   end
endmodule : pim_mapper_tb_top

`default_nettype wire
